// >>> bench/adcs_modulator_model.sv
// far-side model of the analog modulator: a comparator bit held at a level chosen by the bench
`timescale 1ns/1ns

module adcs_modulator_model (
    input wire logic clock_i,
    input wire logic level_i,
    output logic bit_o
);
    always_ff @(posedge clock_i)
    begin
        bit_o <= level_i;
    end
endmodule

// >>> bench/tb.sv
// self-checking bench of the conversion sequencer
`timescale 1ns/1ns

module tb;
    logic clock_i = 1'h0, rst_n_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0, lvl = 1'h0;
    logic [31:0] paddr_i = 32'h0000_0000, pwdata_i = 32'h0000_0000, prdata_o, rd;
    logic pready_o, pslverr_o, err, modulator_bit_i, converter_enable_o, stage1_gain_select_o;
    logic integrator_reset_o, offset_polarity_o, bandgap_state_o, busy_o;
    logic [2:0] stage_enable_o;
    logic [1:0] stage2_gain_select_o;
    logic [3:0] stage2_offset_select_o;
    logic [6:0] stage3_gain_select_o, stage3_offset_select_o;
    logic [15:0] conversion_result_o;
    int n_fail = 0, samples_checked = 0, cycles = 0, ir_cnt = 0;

    adcs_sequencer i_adcs_sequencer (.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .modulator_bit_i(modulator_bit_i),
        .converter_enable_o(converter_enable_o), .stage_enable_o(stage_enable_o),
        .stage1_gain_select_o(stage1_gain_select_o), .stage2_gain_select_o(stage2_gain_select_o),
        .stage2_offset_select_o(stage2_offset_select_o), .stage3_gain_select_o(stage3_gain_select_o),
        .stage3_offset_select_o(stage3_offset_select_o), .integrator_reset_o(integrator_reset_o),
        .offset_polarity_o(offset_polarity_o), .bandgap_state_o(bandgap_state_o), .busy_o(busy_o),
        .conversion_result_o(conversion_result_o));

    adcs_modulator_model i_adcs_modulator_model (.clock_i(clock_i), .level_i(lvl), .bit_o(modulator_bit_i));

    initial
    begin
        forever #50 clock_i = ~clock_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // hang guard and integrator reset pulse counter
    always @(posedge clock_i)
    begin
        cycles <= cycles + 1;
        ir_cnt <= ir_cnt + int'(integrator_reset_o === 1'h1);
        if (cycles == 30000)
        begin
            n_fail = n_fail + 1;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            n_fail = n_fail + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        psel_i <= 1'h1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'h1;
        @(posedge clock_i);
        while (pready_o !== 1'h1)
            @(posedge clock_i);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
        @(posedge clock_i);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        apb(1'h0, 32'h0000_0004, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'h0, 32'h0000_0018, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk({converter_enable_o, stage_enable_o, busy_o}, 32'h0000_0000);
    endtask

    task automatic t_fields();
        apb(1'h1, 32'h0000_0004, 32'h0000_000f);
        @(posedge clock_i);
        chk({stage_enable_o, converter_enable_o}, 32'h0000_000f);
        apb(1'h1, 32'h0000_0004, 32'h0000_0005);
        @(posedge clock_i);
        chk({stage_enable_o, converter_enable_o}, 32'h0000_0005);
        apb(1'h1, 32'h0000_0008, 32'h0000_003a);
        apb(1'h1, 32'h0000_000c, 32'h0000_00c5);
        apb(1'h1, 32'h0000_0010, 32'h0000_005a);
        @(posedge clock_i);
        chk({stage2_gain_select_o, stage2_offset_select_o}, 32'h0000_003a);
        chk({stage1_gain_select_o, stage3_gain_select_o}, 32'h0000_00c5);
        chk(stage3_offset_select_o, 32'h0000_005a);
        apb(1'h0, 32'h0000_000c, 32'h0000_0000);
        chk(rd, 32'h0000_00c5);
    endtask

    task automatic t_unmapped();
        apb(1'h0, 32'h0000_0020, 32'h0000_0000);
        chk({err, rd}, {1'h1, 32'h0000_0000});
        apb(1'h1, 32'h0000_0005, 32'h0000_0001);
        chk(err, 32'h0000_0001);
        chk(busy_o, 32'h0000_0000);
    endtask

    task automatic t_bandgap();
        apb(1'h1, 32'h0000_0014, 32'h0000_0001);
        @(posedge clock_i);
        chk(bandgap_state_o, 32'h0000_0001);
        apb(1'h1, 32'h0000_0014, 32'h0000_0000);
        @(posedge clock_i);
        chk(bandgap_state_o, 32'h0000_0000);
    endtask

    // one conversion at ratio 8; checks hold, length, reset pulses, polarity and result
    task automatic t_conv(input logic [31:0] cfg0, input logic [1:0] rate, input logic l,
            input logic [15:0] exp_res, input int n_el);
        int n;
        int exp_cyc;
        int ir0;
        logic [15:0] prev;
        logic pol_hi;
        exp_cyc = (n_el * 9 + 1) * (160 >> rate) + 2;
        pol_hi = 1'h0;
        lvl <= l;
        apb(1'h1, 32'h0000_0008, {24'h00_0000, rate, 6'h3a});
        prev = conversion_result_o;
        ir0 = ir_cnt;
        apb(1'h1, 32'h0000_0000, cfg0);
        n = 0;
        while (n < exp_cyc / 2)
        begin
            @(posedge clock_i);
            n = n + 1;
            pol_hi = pol_hi | (offset_polarity_o === 1'h1);
        end
        chk(busy_o, 32'h0000_0001);
        chk(conversion_result_o, prev);
        while (busy_o !== 1'h0 && n < 20000)
        begin
            @(posedge clock_i);
            n = n + 1;
            pol_hi = pol_hi | (offset_polarity_o === 1'h1);
        end
        chk(n >= exp_cyc - 2 && n <= exp_cyc + 4, 32'h0000_0001);
        chk(conversion_result_o, exp_res);
        chk(ir_cnt - ir0, n_el);
        if (n_el > 1)
            chk(pol_hi, 32'h0000_0001);
    endtask

    initial
    begin
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'h1;
        @(posedge clock_i);
        t_reset();
        t_fields();
        t_unmapped();
        t_bandgap();
        t_conv(32'h0000_0001, 2'h3, 1'h1, 16'h7fff, 1);
        t_conv(32'h0000_0022, 2'h3, 1'h1, 16'h0100, 2);
        t_conv(32'h0000_0001, 2'h2, 1'h0, 16'h8000, 1);
        print_verdict();
    end
endmodule

// >>> hw/adcs_consts.svh
// register map, field positions and timing figures of the conversion sequencer
`ifndef ADCS_CONSTS_SVH
`define ADCS_CONSTS_SVH

`define ADCS_CLK_HZ 10000000
`define ADCS_FS_BASE_HZ 62500
`define ADCS_FS_DIV_BASE ((`ADCS_CLK_HZ) / (`ADCS_FS_BASE_HZ))

`define ADCS_OFF_CFG0 6'h00
`define ADCS_OFF_ENABLE 6'h01
`define ADCS_OFF_CFG2 6'h02
`define ADCS_OFF_CFG3 6'h03
`define ADCS_OFF_CFG4 6'h04
`define ADCS_OFF_CFG5 6'h05
`define ADCS_OFF_RESULT 6'h06
`define ADCS_OFF_STATUS 6'h07

`define ADCS_CFG0_START 0
`define ADCS_CFG0_ALT 1
`define ADCS_CFG0_RATIO_LSB 2
`define ADCS_CFG0_NELC_LSB 5

`define ADCS_RES_BITS 5'h10
`define ADCS_OSR_LOG2_BASE 5'h06
`define ADCS_RESULT_MAX 16'h7fff
`define ADCS_RESULT_MIN 16'h8000

`define ADCS_BG_LOW 2'h0
`define ADCS_BG_HIGH 2'h1
`define ADCS_BG_TOGGLE 2'h2
`define ADCS_BG_TOGGLE_HALF 2'h3

`endif

// >>> hw/adcs_pkg.sv
// types shared by the conversion sequencer
package adcs_pkg;
    typedef enum logic [4:0] {
        ADCS_IDLE = 5'b00001,
        ADCS_INIT = 5'b00010,
        ADCS_ELEM = 5'b00100,
        ADCS_FINAL = 5'b01000,
        ADCS_DONE = 5'b10000
    } adcs_state_t;
endpackage

// >>> hw/adcs_sequencer.sv
// incremental adc conversion sequencer with apb register access
//
// Contract
// - a write setting start or the alternate trigger begins a sequence
// - a sequence is the programmed elementary conversions then one final step
// - each elementary conversion lasts ratio plus one oversampling periods
// - the result is the mean of all elementary results
// - successive elementary conversions flip offset polarity
// - rate select divides the oscillator to 62.5, 125, 250 or 500 kHz
// - ratio select gives two to the three plus field integration cycles
// - count select gives two to the field elementary conversions
// - resolution is twice log2 ratio plus log2 count, capped at 16
// - a sequence takes count times ratio plus one, plus one periods
// - a few extra clock cycles start and finish a sequence
// - the result is sixteen bit two's complement
// - out-of-range results clamp to 0x7fff or 0x8000
// - below sixteen bits the unused low bits are forced
// - the forced pattern is a one under the last valid bit, then zeros
// - software enables or bypasses each gain stage and the converter
// - enable word bit 0 converter, bits 1 to 3 the gain stages
// - one bit selects stage one gain of one or ten
// - stage two takes a 2-bit gain and 4-bit offset select
// - stage three takes a 7-bit gain and 7-bit offset select
// - bandgap forced low, high, or toggled per elementary or every second
`timescale 1ns/1ns
`include "adcs_consts.svh"

module adcs_sequencer (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic modulator_bit_i,
    output logic converter_enable_o,
    output logic [2:0] stage_enable_o,
    output logic stage1_gain_select_o,
    output logic [1:0] stage2_gain_select_o,
    output logic [3:0] stage2_offset_select_o,
    output logic [6:0] stage3_gain_select_o,
    output logic [6:0] stage3_offset_select_o,
    output logic integrator_reset_o,
    output logic offset_polarity_o,
    output logic bandgap_state_o,
    output logic busy_o,
    output logic [15:0] conversion_result_o
);

    ////////////////////////////////////////////////////////////////////////////
    // apb slave and configuration registers

    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic [3:0] enable_reg;
    logic [2:0] ratio_select_reg;
    logic [1:0] elementary_count_select_reg;
    logic [1:0] sample_rate_select_reg;
    logic stage1_gain_select_reg;
    logic [1:0] stage2_gain_select_reg;
    logic [3:0] stage2_offset_select_reg;
    logic [6:0] stage3_gain_select_reg;
    logic [6:0] stage3_offset_select_reg;
    logic [1:0] bandgap_mode_reg;
    logic [15:0] conversion_result_reg;
    adcs_pkg::adcs_state_t state_reg;

    logic access;
    logic addr_ok;
    logic [5:0] word_idx;
    logic wr_cfg0;
    logic start_req;

    assign word_idx = paddr_i[7:2];
    assign addr_ok = (paddr_i[31:8] == 24'h00_0000) && (paddr_i[1:0] == 2'h0) && (word_idx <= `ADCS_OFF_STATUS);
    assign access = psel_i && penable_i && pready_reg;
    assign wr_cfg0 = access && pwrite_i && addr_ok && (word_idx == `ADCS_OFF_CFG0);
    assign start_req = wr_cfg0 && (pwdata_i[`ADCS_CFG0_START] || pwdata_i[`ADCS_CFG0_ALT]);

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg <= psel_i && penable_i && !pready_reg;
            pslverr_reg <= psel_i && penable_i && !pready_reg && !addr_ok;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            prdata_reg <= 32'h0000_0000;
        else if (psel_i && penable_i && !pready_reg)
        begin
            case (addr_ok ? word_idx : 6'h3f)
                `ADCS_OFF_CFG0: prdata_reg <= {25'h000_0000, elementary_count_select_reg, ratio_select_reg, 2'h0};
                `ADCS_OFF_ENABLE: prdata_reg <= {28'h000_0000, enable_reg};
                `ADCS_OFF_CFG2: prdata_reg <= {24'h00_0000, sample_rate_select_reg, stage2_gain_select_reg,
                                               stage2_offset_select_reg};
                `ADCS_OFF_CFG3: prdata_reg <= {24'h00_0000, stage1_gain_select_reg, stage3_gain_select_reg};
                `ADCS_OFF_CFG4: prdata_reg <= {25'h000_0000, stage3_offset_select_reg};
                `ADCS_OFF_CFG5: prdata_reg <= {30'h0000_0000, bandgap_mode_reg};
                `ADCS_OFF_RESULT: prdata_reg <= {16'h0000, conversion_result_reg};
                `ADCS_OFF_STATUS: prdata_reg <= {31'h0000_0000, state_reg != adcs_pkg::ADCS_IDLE};
                default: prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            enable_reg <= 4'h0;
            ratio_select_reg <= 3'h0;
            elementary_count_select_reg <= 2'h0;
            sample_rate_select_reg <= 2'h0;
            stage1_gain_select_reg <= 1'b0;
            stage2_gain_select_reg <= 2'h0;
            stage2_offset_select_reg <= 4'h0;
            stage3_gain_select_reg <= 7'h00;
            stage3_offset_select_reg <= 7'h00;
            bandgap_mode_reg <= 2'h0;
        end
        else if (access && pwrite_i && addr_ok)
        begin
            case (word_idx)
                `ADCS_OFF_CFG0:
                begin
                    ratio_select_reg <= pwdata_i[`ADCS_CFG0_RATIO_LSB +: 3];
                    elementary_count_select_reg <= pwdata_i[`ADCS_CFG0_NELC_LSB +: 2];
                end
                `ADCS_OFF_ENABLE: enable_reg <= pwdata_i[3:0];
                `ADCS_OFF_CFG2:
                begin
                    sample_rate_select_reg <= pwdata_i[7:6];
                    stage2_gain_select_reg <= pwdata_i[5:4];
                    stage2_offset_select_reg <= pwdata_i[3:0];
                end
                `ADCS_OFF_CFG3:
                begin
                    stage1_gain_select_reg <= pwdata_i[7];
                    stage3_gain_select_reg <= pwdata_i[6:0];
                end
                `ADCS_OFF_CFG4: stage3_offset_select_reg <= pwdata_i[6:0];
                `ADCS_OFF_CFG5: bandgap_mode_reg <= pwdata_i[1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser and oversampling clock enable

    logic mod_meta_reg;
    logic mod_bit_reg;
    logic [7:0] div_cnt_reg;
    logic [7:0] div_limit;
    logic fs_tick;
    logic [1:0] run_rate_reg;

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            mod_meta_reg <= 1'b0;
            mod_bit_reg <= 1'b0;
        end
        else
        begin
            mod_meta_reg <= modulator_bit_i;
            mod_bit_reg <= mod_meta_reg;
        end
    end

    assign div_limit = 8'(`ADCS_FS_DIV_BASE) >> run_rate_reg;
    assign fs_tick = (div_cnt_reg == 8'h00);

    // divider restarts on init so the first period is a whole one
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            div_cnt_reg <= 8'h00;
        else if (state_reg == adcs_pkg::ADCS_INIT || fs_tick)
            div_cnt_reg <= div_limit - 8'h01;
        else
            div_cnt_reg <= div_cnt_reg - 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequence control

    logic [2:0] run_ratio_reg;
    logic [1:0] run_nelc_reg;
    logic [10:0] tick_cnt_reg;
    logic [3:0] elem_cnt_reg;
    logic [10:0] oversampling_ratio;
    logic [3:0] nelc;
    logic elem_end;
    logic last_elem;

    assign oversampling_ratio = 11'h008 << run_ratio_reg;
    assign nelc = 4'h1 << run_nelc_reg;
    assign elem_end = (state_reg == adcs_pkg::ADCS_ELEM) && fs_tick && (tick_cnt_reg == oversampling_ratio);
    assign last_elem = (elem_cnt_reg == nelc - 4'h1);

    // a start while busy is ignored; settings are captured at start
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            state_reg <= adcs_pkg::ADCS_IDLE;
        else
        begin
            case (state_reg)
                adcs_pkg::ADCS_IDLE:
                    if (start_req)
                        state_reg <= adcs_pkg::ADCS_INIT;
                adcs_pkg::ADCS_INIT: state_reg <= adcs_pkg::ADCS_ELEM;
                adcs_pkg::ADCS_ELEM:
                    if (elem_end && last_elem)
                        state_reg <= adcs_pkg::ADCS_FINAL;
                adcs_pkg::ADCS_FINAL:
                    if (fs_tick)
                        state_reg <= adcs_pkg::ADCS_DONE;
                adcs_pkg::ADCS_DONE: state_reg <= adcs_pkg::ADCS_IDLE;
                default: state_reg <= adcs_pkg::ADCS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            run_ratio_reg <= 3'h0;
            run_nelc_reg <= 2'h0;
            run_rate_reg <= 2'h0;
        end
        else if (state_reg == adcs_pkg::ADCS_IDLE && start_req)
        begin
            run_ratio_reg <= wr_cfg0 ? pwdata_i[`ADCS_CFG0_RATIO_LSB +: 3] : ratio_select_reg;
            run_nelc_reg <= wr_cfg0 ? pwdata_i[`ADCS_CFG0_NELC_LSB +: 2] : elementary_count_select_reg;
            run_rate_reg <= sample_rate_select_reg;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            tick_cnt_reg <= 11'h000;
            elem_cnt_reg <= 4'h0;
        end
        else if (state_reg == adcs_pkg::ADCS_INIT)
        begin
            tick_cnt_reg <= 11'h000;
            elem_cnt_reg <= 4'h0;
        end
        else if (state_reg == adcs_pkg::ADCS_ELEM && fs_tick)
        begin
            tick_cnt_reg <= elem_end ? 11'h000 : tick_cnt_reg + 11'h001;
            if (elem_end)
                elem_cnt_reg <= elem_cnt_reg + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // second-order incremental integration and averaging

    logic signed [11:0] acc1_reg;
    logic signed [21:0] acc2_reg;
    logic signed [24:0] sum_reg;
    logic signed [11:0] acc1_next;
    logic polarity_reg;

    // chopped amplifiers invert the signal on odd passes; undo it here
    assign acc1_next = acc1_reg + ((mod_bit_reg ^ polarity_reg) ? 12'sh001 : 12'shfff);

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i || state_reg == adcs_pkg::ADCS_INIT || elem_end)
        begin
            acc1_reg <= 12'sh000;
            acc2_reg <= 22'sh00_0000;
        end
        else if (state_reg == adcs_pkg::ADCS_ELEM && fs_tick)
        begin
            acc1_reg <= acc1_next;
            acc2_reg <= acc2_reg + 22'(acc1_next);
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i || state_reg == adcs_pkg::ADCS_INIT)
            sum_reg <= 25'sh000_0000;
        else if (elem_end)
            sum_reg <= sum_reg + 25'(acc2_reg);
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i || state_reg == adcs_pkg::ADCS_INIT)
            polarity_reg <= 1'b0;
        else if (elem_end)
            polarity_reg <= !polarity_reg;
    end

    // integrators in the analog chain are cleared before each elementary pass
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            integrator_reset_o <= 1'b0;
        else
            integrator_reset_o <= (state_reg == adcs_pkg::ADCS_INIT) || (elem_end && !last_elem);
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            bandgap_state_o <= 1'b0;
        else
        begin
            case (bandgap_mode_reg)
                `ADCS_BG_LOW: bandgap_state_o <= 1'b0;
                `ADCS_BG_HIGH: bandgap_state_o <= 1'b1;
                `ADCS_BG_TOGGLE:
                    if (elem_end)
                        bandgap_state_o <= !bandgap_state_o;
                `ADCS_BG_TOGGLE_HALF:
                    if (elem_end && elem_cnt_reg[0])
                        bandgap_state_o <= !bandgap_state_o;
                default: bandgap_state_o <= 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // scaling, forced low bits and saturation

    logic [4:0] res_bits;
    logic signed [39:0] scaled;
    logic [15:0] result_next;

    // full scale of the mean is ratio squared over two, mapped onto 2^15
    assign res_bits = {1'b0, run_ratio_reg, 1'b0} + `ADCS_OSR_LOG2_BASE + {3'h0, run_nelc_reg};

    always_comb
    begin
        scaled = 40'(sum_reg);
        if (res_bits <= `ADCS_RES_BITS)
            scaled = scaled <<< (`ADCS_RES_BITS - res_bits);
        else
            scaled = scaled >>> (res_bits - `ADCS_RES_BITS);
        if (res_bits < `ADCS_RES_BITS)
            scaled = scaled | (40'sh1 <<< (`ADCS_RES_BITS - 5'h01 - res_bits));
        if (scaled > 40'($signed(`ADCS_RESULT_MAX)))
            result_next = `ADCS_RESULT_MAX;
        else if (scaled < -40'sh80_00)
            result_next = `ADCS_RESULT_MIN;
        else
            result_next = scaled[15:0];
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            conversion_result_reg <= 16'h0000;
        else if (state_reg == adcs_pkg::ADCS_DONE)
            conversion_result_reg <= result_next;
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            busy_o <= 1'b0;
        else
            busy_o <= (state_reg != adcs_pkg::ADCS_IDLE) && (state_reg != adcs_pkg::ADCS_DONE) || start_req;
    end

    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign offset_polarity_o = polarity_reg;
    assign conversion_result_o = conversion_result_reg;
    assign converter_enable_o = enable_reg[0];
    assign stage_enable_o = enable_reg[3:1];
    assign stage1_gain_select_o = stage1_gain_select_reg;
    assign stage2_gain_select_o = stage2_gain_select_reg;
    assign stage2_offset_select_o = stage2_offset_select_reg;
    assign stage3_gain_select_o = stage3_gain_select_reg;
    assign stage3_offset_select_o = stage3_offset_select_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    logic [13:0] seq_ticks_reg;
    logic [7:0] gap_reg;

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i || state_reg == adcs_pkg::ADCS_INIT)
            seq_ticks_reg <= 14'h0000;
        else if (fs_tick && (state_reg == adcs_pkg::ADCS_ELEM || state_reg == adcs_pkg::ADCS_FINAL))
            seq_ticks_reg <= seq_ticks_reg + 14'h0001;
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i || fs_tick || state_reg == adcs_pkg::ADCS_INIT)
            gap_reg <= 8'h01;
        else
            gap_reg <= gap_reg + 8'h01;
    end

    chk_start_begins: assert property ((state_reg == adcs_pkg::ADCS_IDLE && start_req)
        |=> state_reg == adcs_pkg::ADCS_INIT ##1 state_reg == adcs_pkg::ADCS_ELEM)
        else $error("start did not launch a sequence");

    chk_elem_count: assert property ($rose(state_reg == adcs_pkg::ADCS_FINAL) |-> elem_cnt_reg == nelc)
        else $error("wrong number of elementary conversions");

    chk_elem_length: assert property (elem_end |-> $past(tick_cnt_reg) == oversampling_ratio)
        else $error("elementary conversion length wrong");

    chk_polarity_flip: assert property ((elem_end && !last_elem) |=> offset_polarity_o != $past(offset_polarity_o))
        else $error("offset polarity did not alternate");

    chk_rate_period: assert property ((state_reg == adcs_pkg::ADCS_ELEM && fs_tick && $past(state_reg) == adcs_pkg::ADCS_ELEM)
        |-> gap_reg == div_limit)
        else $error("oversampling period wrong");

    chk_total_ticks: assert property ((state_reg == adcs_pkg::ADCS_DONE)
        |-> seq_ticks_reg == 14'(nelc) * 14'(oversampling_ratio + 11'h001) + 14'h0001)
        else $error("sequence length in oversampling periods wrong");

    chk_result_hold: assert property ((state_reg != adcs_pkg::ADCS_DONE) |=> $stable(conversion_result_o))
        else $error("result changed outside completion");

    chk_forced_lsb: assert property ((state_reg == adcs_pkg::ADCS_DONE && res_bits < `ADCS_RES_BITS
        && result_next != `ADCS_RESULT_MAX && result_next != `ADCS_RESULT_MIN)
        |=> (conversion_result_o & ((16'h0002 << (`ADCS_RES_BITS - 5'h01 - $past(res_bits))) - 16'h0001))
            == (16'h0001 << (`ADCS_RES_BITS - 5'h01 - $past(res_bits))))
        else $error("forced low bits wrong");

endmodule
